/* File: design/pct_pkg.sv */
package pct_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CTRL  = 8'hD8;
  localparam logic [7:0] ADDR_MODE  = 8'hED;
  localparam logic [7:0] ADDR_PWM   = 8'hA1;
  localparam logic [7:0] ADDR_CPL0  = 8'hF1;
  localparam int         NUM_MOD    = 3;
  // field positions
  localparam int CTRL_CF  = 7;
  localparam int CTRL_CR  = 6;
  localparam int MODE_IDLE_SUSPEND = 7;
  localparam int MODE_CPS_LO = 1;
  localparam int MODE_ECF = 0;
  localparam int PWM_RELOAD_REGISTER_SELECT = 7;
  localparam int PWM_CYCLE_OVERFLOW_IRQ_ENABLE = 6;
  localparam int PWM_CYCLE_OVERFLOW_FLAG = 5;
  localparam int PWM_CLSEL_LO = 0;
  localparam int CNT_W = 16;
  // timebase codes
  localparam logic [2:0] CPS_DIV12 = 3'h0;
  localparam logic [2:0] CPS_DIV4  = 3'h1;
  localparam logic [2:0] CPS_T0    = 3'h2;
  localparam logic [2:0] CPS_ECI   = 3'h3;
  localparam logic [2:0] CPS_SYS   = 3'h4;
  localparam logic [2:0] CPS_EXT8  = 3'h5;
  // prescaler terminal counts
  localparam logic [3:0] PRE12_LAST = 4'hB;
  localparam logic [3:0] PRE4_LAST  = 4'h3;
  localparam logic [2:0] EXT8_LAST  = 3'h7;
  localparam logic [1:0] CLSEL_8BIT = 2'h0;
  localparam logic [7:0] RD_ZERO    = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pct_sfr_req_t;

  typedef struct packed {
    logic [NUM_MOD-1:0] pwm_en;
    logic [NUM_MOD-1:0] pwm16;
  } pct_mod_mode_t;
endpackage

/* File: design/pct_sync.sv */
`timescale 1ns/1ps
module pct_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

/* File: design/pct_timebase.sv */
`timescale 1ns/1ps
// What this block does
// - idle_suspend set: counter array halts while the cpu idles
// - unused configuration bits read zero and ignore writes
// - timebase 000 sysclk/12, 001 sysclk/4, 100 sysclk
// - timebase 010 counts timer zero overflows
// - timebase 011 counts falling edges of external count input, max sysclk/4
// - timebase 101 counts external oscillator divided by eight, synchronised
// - counter overflow flag with its enable raises the interrupt request
// - reload_register_select steers compare byte accesses to reload registers
// - reload registers act only in 9, 10 and 11-bit pwm
// - cycle overflow flag with its enable raises the interrupt request
// - cycle overflow flag set on carry out of selected bit
// - cycle overflow flag set by hardware or software write, software clears
// - cycle length field 00..11 selects 8..11 bits
// - cycle length applies to all non-16-bit pwm modules
// - counter wrap from all ones sets overflow flag, software clears
// - counter advances only while counter_run is one
// - on cycle carry in 9-11 bit pwm, reload copied into compare
module pct_timebase (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  // sfr access
  input  wire pct_pkg::pct_sfr_req_t         sfr_req,
  output logic      [7:0]                    sfr_rdata_q,
  // system events and pins
  input  wire logic                          cpu_idle,
  input  wire logic                          timer0_overflow,
  input  wire logic                          external_count_input,
  input  wire logic                          ext_osc_clk,
  input  wire pct_pkg::pct_mod_mode_t        mod_mode,
  // results
  output logic      [pct_pkg::CNT_W-1:0]     counter_value_q,
  output logic      [pct_pkg::NUM_MOD*16-1:0] module_compare_value_q,
  output logic                               irq_q
);
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic       eci_s, osc_s, eci_prev_q, osc_prev_q;
  logic       cf_q, cr_q, idle_suspend_q, ecf_q, reload_register_select_q, cycle_overflow_irq_enable_q, cycle_overflow_flag_q;
  logic [2:0] cps_q;
  logic [1:0] clsel_q;
  logic [3:0] pre_q;
  logic [2:0] ext_div_q;
  logic       tick, run_ok, inc, wrap, cyc_carry;
  logic [15:0] arl_q [pct_pkg::NUM_MOD];
  logic [pct_pkg::NUM_MOD-1:0] reload_en;
  logic       wr_ctrl, wr_mode, wr_pwm;

  // async assert, synchronous release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  pct_sync #(.W(2)) u_pin_sync (
    .clk  (sys_clk),
    .rst_n(rst_n),
    .din  ({external_count_input, ext_osc_clk}),
    .dout ({eci_s, osc_s})
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eci_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      eci_prev_q <= eci_s;
      osc_prev_q <= osc_s;
    end
  end

  assign wr_ctrl = sfr_req.wr && (sfr_req.addr == pct_pkg::ADDR_CTRL);
  assign wr_mode = sfr_req.wr && (sfr_req.addr == pct_pkg::ADDR_MODE);
  assign wr_pwm  = sfr_req.wr && (sfr_req.addr == pct_pkg::ADDR_PWM);

  // suspend freezes everything, prescalers included
  assign run_ok = cr_q && !(idle_suspend_q && cpu_idle);

  // sysclk prescaler, held at zero while the select is on neither divided code
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pre_q <= 4'h0;
    else if (!run_ok) pre_q <= pre_q;
    else if ((cps_q == pct_pkg::CPS_DIV12 && pre_q == pct_pkg::PRE12_LAST) ||
             (cps_q == pct_pkg::CPS_DIV4 && pre_q == pct_pkg::PRE4_LAST) ||
             (cps_q != pct_pkg::CPS_DIV12 && cps_q != pct_pkg::CPS_DIV4))
      pre_q <= 4'h0;
    else pre_q <= pre_q + 4'h1;
  end

  // oscillator edges counted at sysclk, so osc must stay below sysclk/2
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) ext_div_q <= 3'h0;
    else if (run_ok && osc_s && !osc_prev_q) ext_div_q <= ext_div_q + 3'h1;
  end

  always_comb begin
    case (cps_q)
      pct_pkg::CPS_DIV12: tick = (pre_q == pct_pkg::PRE12_LAST);
      pct_pkg::CPS_DIV4:  tick = (pre_q == pct_pkg::PRE4_LAST);
      pct_pkg::CPS_T0:    tick = timer0_overflow;
      pct_pkg::CPS_ECI:   tick = eci_prev_q && !eci_s;
      pct_pkg::CPS_SYS:   tick = 1'b1;
      pct_pkg::CPS_EXT8:  tick = osc_s && !osc_prev_q && ext_div_q == pct_pkg::EXT8_LAST;
      default:            tick = 1'b0; // reserved codes hold the count
    endcase
  end

  assign inc  = tick && run_ok;
  assign wrap = inc && (&counter_value_q);

  always_comb begin
    case (clsel_q)
      2'h0:    cyc_carry = inc && (&counter_value_q[7:0]);
      2'h1:    cyc_carry = inc && (&counter_value_q[8:0]);
      2'h2:    cyc_carry = inc && (&counter_value_q[9:0]);
      default: cyc_carry = inc && (&counter_value_q[10:0]);
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) counter_value_q <= '0;
    else if (inc) counter_value_q <= counter_value_q + 16'h1;
  end

  // control register: flag set wins over a software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cf_q <= 1'b0;
      cr_q <= 1'b0;
    end else begin
      if (wr_ctrl) cr_q <= sfr_req.wdata[pct_pkg::CTRL_CR];
      if (wrap) cf_q <= 1'b1;
      else if (wr_ctrl) cf_q <= sfr_req.wdata[pct_pkg::CTRL_CF];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_suspend_q <= 1'b0;
      cps_q  <= pct_pkg::CPS_DIV12;
      ecf_q  <= 1'b0;
    end else if (wr_mode) begin // bits 6:4 dropped
      idle_suspend_q <= sfr_req.wdata[pct_pkg::MODE_IDLE_SUSPEND];
      cps_q  <= sfr_req.wdata[pct_pkg::MODE_CPS_LO +: 3];
      ecf_q  <= sfr_req.wdata[pct_pkg::MODE_ECF];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_register_select_q <= 1'b0;
      cycle_overflow_irq_enable_q  <= 1'b0;
      cycle_overflow_flag_q  <= 1'b0;
      clsel_q <= pct_pkg::CLSEL_8BIT;
    end else begin
      if (wr_pwm) begin // bits 4:2 dropped
        reload_register_select_q <= sfr_req.wdata[pct_pkg::PWM_RELOAD_REGISTER_SELECT];
        cycle_overflow_irq_enable_q  <= sfr_req.wdata[pct_pkg::PWM_CYCLE_OVERFLOW_IRQ_ENABLE];
        clsel_q <= sfr_req.wdata[pct_pkg::PWM_CLSEL_LO +: 2];
      end
      if (cyc_carry) cycle_overflow_flag_q <= 1'b1;
      else if (wr_pwm) cycle_overflow_flag_q <= sfr_req.wdata[pct_pkg::PWM_CYCLE_OVERFLOW_FLAG];
    end
  end

  // reload only for 9-11 bit pwm; 16-bit modules ignore cycle length
  always_comb begin
    for (int m = 0; m < pct_pkg::NUM_MOD; m++) begin
      reload_en[m] = cyc_carry && mod_mode.pwm_en[m] && !mod_mode.pwm16[m] &&
                     (clsel_q != pct_pkg::CLSEL_8BIT);
    end
  end

  // compare/reload storage; hardware reload beats a same-cycle write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      module_compare_value_q <= '0;
      for (int m = 0; m < pct_pkg::NUM_MOD; m++) arl_q[m] <= 16'h0;
    end else begin
      for (int m = 0; m < pct_pkg::NUM_MOD; m++) begin
        if (reload_en[m]) module_compare_value_q[m*16 +: 16] <= arl_q[m];
        else if (sfr_req.wr && !reload_register_select_q &&
                 sfr_req.addr == pct_pkg::ADDR_CPL0 + 8'(2*m))
          module_compare_value_q[m*16 +: 8] <= sfr_req.wdata;
        else if (sfr_req.wr && !reload_register_select_q &&
                 sfr_req.addr == pct_pkg::ADDR_CPL0 + 8'(2*m+1))
          module_compare_value_q[m*16+8 +: 8] <= sfr_req.wdata;
        if (sfr_req.wr && reload_register_select_q && sfr_req.addr == pct_pkg::ADDR_CPL0 + 8'(2*m))
          arl_q[m][7:0] <= sfr_req.wdata;
        else if (sfr_req.wr && reload_register_select_q &&
                 sfr_req.addr == pct_pkg::ADDR_CPL0 + 8'(2*m+1))
          arl_q[m][15:8] <= sfr_req.wdata;
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) sfr_rdata_q <= pct_pkg::RD_ZERO;
    else if (sfr_req.rd) begin
      sfr_rdata_q <= pct_pkg::RD_ZERO;
      if (sfr_req.addr == pct_pkg::ADDR_CTRL) sfr_rdata_q <= {cf_q, cr_q, 6'h00};
      else if (sfr_req.addr == pct_pkg::ADDR_MODE)
        sfr_rdata_q <= {idle_suspend_q, 3'h0, cps_q, ecf_q};
      else if (sfr_req.addr == pct_pkg::ADDR_PWM)
        sfr_rdata_q <= {reload_register_select_q, cycle_overflow_irq_enable_q, cycle_overflow_flag_q, 3'h0, clsel_q};
      else begin
        for (int m = 0; m < pct_pkg::NUM_MOD; m++) begin
          if (sfr_req.addr == pct_pkg::ADDR_CPL0 + 8'(2*m))
            sfr_rdata_q <= reload_register_select_q ? arl_q[m][7:0] : module_compare_value_q[m*16 +: 8];
          else if (sfr_req.addr == pct_pkg::ADDR_CPL0 + 8'(2*m+1))
            sfr_rdata_q <= reload_register_select_q ? arl_q[m][15:8] : module_compare_value_q[m*16+8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) irq_q <= 1'b0;
    else irq_q <= (cf_q && ecf_q) || (cycle_overflow_flag_q && cycle_overflow_irq_enable_q);
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_CF_IRQ: assert property (cf_q && ecf_q |=> irq_q)
    else $error("overflow irq missing");
  AST_IRQ_MASK: assert property ((!cf_q || !ecf_q) && (!cycle_overflow_flag_q || !cycle_overflow_irq_enable_q) |=> !irq_q)
    else $error("masked irq raised");
  AST_COV_IRQ: assert property (cycle_overflow_flag_q && cycle_overflow_irq_enable_q |=> irq_q)
    else $error("cycle irq missing");
  AST_IDLE_HOLD: assert property (idle_suspend_q && cpu_idle |=> $stable(counter_value_q))
    else $error("counter moved in idle");
  AST_RUN_HOLD: assert property (!cr_q |=> $stable(counter_value_q))
    else $error("counter moved while stopped");
  AST_WRAP_CF: assert property (wrap |=> cf_q && counter_value_q == 16'h0)
    else $error("wrap did not set flag");
  AST_CYCLE_OVERFLOW_FLAG_SET: assert property (cyc_carry |=> cycle_overflow_flag_q)
    else $error("cycle carry lost");
  AST_RELOAD0: assert property (reload_en[0] |=>
      module_compare_value_q[15:0] == $past(arl_q[0]))
    else $error("reload not applied");
  AST_SYS_RATE: assert property (cps_q == pct_pkg::CPS_SYS && run_ok |=>
      counter_value_q == $past(counter_value_q) + 16'h1)
    else $error("sysclk rate wrong");
  // a select change right after a tick restarts the spacing, so only div12 ticks count
  AST_DIV12: assert property (cps_q == pct_pkg::CPS_DIV12 && inc |=>
      (!inc || cps_q != pct_pkg::CPS_DIV12) [*8])
    else $error("div12 ticks too close");
  AST_RSVD_RD: assert property (sfr_req.rd && sfr_req.addr == pct_pkg::ADDR_PWM |=>
      sfr_rdata_q[4:2] == 3'h0)
    else $error("reserved bits not zero");

  COV_WRAP:   cover property (wrap);
  COV_RELOAD: cover property (reload_en != '0);
  COV_ECI:    cover property (cps_q == pct_pkg::CPS_ECI && inc);
endmodule

/* File: verif/pct_timebase_test.sv */
`timescale 1ns/1ps
module pct_timebase_test;
  logic                   sys_clk;
  logic                   reset_n;
  pct_pkg::pct_sfr_req_t  sfr_req;
  logic [7:0]             sfr_rdata_q;
  logic                   cpu_idle;
  logic [2:0]             pv;
  pct_pkg::pct_mod_mode_t mod_mode;
  logic [15:0]            counter_value_q;
  logic [47:0]            module_compare_value_q;
  logic                   irq_q;
  logic                   seen;
  logic [15:0]            cv [3];
  logic [15:0]            rv [3];
  int                     err_count = 0;
  int                     checks = 0;

  pct_timebase DUT (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .sfr_req               (sfr_req),
    .sfr_rdata_q           (sfr_rdata_q),
    .cpu_idle              (cpu_idle),
    .timer0_overflow       (pv[0]),
    .external_count_input  (pv[1]),
    .ext_osc_clk           (pv[2]),
    .mod_mode              (mod_mode),
    .counter_value_q       (counter_value_q),
    .module_compare_value_q(module_compare_value_q),
    .irq_q                 (irq_q)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic report(input logic ok, input logic [47:0] g, input logic [47:0] e);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    report(g === e, 48'(g), 48'(e));
  endtask
  task automatic cmp_val(input logic [47:0] g, input logic [47:0] e);
    report(g === e, g, e);
  endtask
  task automatic cmp_irq(input logic g, input logic e);
    report(g === e, 48'(g), 48'(e));
  endtask

  // request held one cycle, taken at the following edge
  task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 sfr_req = '{a, d, wr, !wr};
    @(posedge sys_clk);
    #1 sfr_req = '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    sfr(1'b0, a, 8'h00);
    cmp_reg(sfr_rdata_q, e);
  endtask

  task automatic span(input int n, input logic [15:0] e);
    logic [15:0] v0;
    v0 = counter_value_q;
    repeat (n) @(posedge sys_clk);
    #1 cmp_val(48'(counter_value_q - v0), 48'(e));
  endtask

  // toggles one event pin away from idle and back, n times
  task automatic pins(input int sel, input int n, input int half, input logic [15:0] e);
    logic [15:0] v0;
    v0 = counter_value_q;
    repeat (n) begin
      pv[sel] = ~pv[sel];
      repeat (half) @(posedge sys_clk);
      #1 pv[sel] = ~pv[sel];
      repeat (half) @(posedge sys_clk);
      #1;
    end
    repeat (8) @(posedge sys_clk);
    #1 cmp_val(48'(counter_value_q - v0), 48'(e));
  endtask

  task automatic wait_cnt(input logic [15:0] m);
    int i;
    seen = 1'b0;
    i = 0;
    while ((counter_value_q & m) !== m && i < 70000) begin
      @(posedge sys_clk);
      #1 seen = seen | irq_q;
      i++;
    end
    cmp_irq(i < 70000, 1'b1);
  endtask

  initial begin
    #380000;
    err_count++;
    print_verdict();
  end

  initial begin
    int k;
    int dv [3] = '{12, 4, 1};
    logic [7:0] code [3] = '{8'h00, 8'h02, 8'h08};
    reset_n = 1'b0;
    sfr_req = '0;
    cpu_idle = 1'b0;
    pv = 3'b010;
    mod_mode = '0;
    void'($urandom(32'h83FC));
    repeat (12) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk(pct_pkg::ADDR_MODE, 8'h00);
    rd_chk(pct_pkg::ADDR_PWM, 8'h00);
    rd_chk(pct_pkg::ADDR_CTRL, 8'h00);
    cmp_irq(irq_q, 1'b0);
    sfr(1'b1, pct_pkg::ADDR_MODE, 8'hF7);
    rd_chk(pct_pkg::ADDR_MODE, 8'h87);
    sfr(1'b1, pct_pkg::ADDR_PWM, 8'hFF);
    rd_chk(pct_pkg::ADDR_PWM, 8'hE3);
    sfr(1'b1, pct_pkg::ADDR_PWM, 8'h00);
    rd_chk(pct_pkg::ADDR_PWM, 8'h00);
    // divided and undivided system clock, random window lengths
    sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h40);
    for (int j = 0; j < 3; j++) begin
      sfr(1'b1, pct_pkg::ADDR_MODE, code[j]);
      k = $urandom_range(5, 1);
      span(12 * k, 16'(12 * k / dv[j]));
    end
    sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h00);
    span(48, 16'h0000);
    sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h40);
    sfr(1'b1, pct_pkg::ADDR_MODE, 8'h88);
    #0 cpu_idle = 1'b1;
    span(48, 16'h0000);
    cpu_idle = 1'b0;
    span(48, 16'h0030);
    sfr(1'b1, pct_pkg::ADDR_MODE, 8'h04);
    k = $urandom_range(20, 1);
    pins(0, k, 1, 16'(k));
    sfr(1'b1, pct_pkg::ADDR_MODE, 8'h06);
    k = $urandom_range(8, 1);
    pins(1, k, 4, 16'(k));
    sfr(1'b1, pct_pkg::ADDR_MODE, 8'h0A);
    pins(2, 16, 3, 16'h0002);
    // cycle carry per length code, enable on, overflow masked
    sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h00);
    sfr(1'b1, pct_pkg::ADDR_MODE, 8'h08);
    for (int c = 0; c < 4; c++) begin
      sfr(1'b1, pct_pkg::ADDR_PWM, 8'h40 | 8'(c));
      sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h40);
      wait_cnt(16'((256 << c) - 1));
      cmp_irq(seen, 1'b0);
      repeat (2) @(posedge sys_clk);
      #1 cmp_irq(irq_q, 1'b1);
      sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h00);
    end
    sfr(1'b1, pct_pkg::ADDR_PWM, 8'h21);
    @(posedge sys_clk);
    #1 cmp_irq(irq_q, 1'b0);
    sfr(1'b1, pct_pkg::ADDR_PWM, 8'h61);
    @(posedge sys_clk);
    #1 cmp_irq(irq_q, 1'b1);
    sfr(1'b1, pct_pkg::ADDR_PWM, 8'h01);
    // module 0 reloads, module 1 in 16-bit mode, module 2 not in pwm
    mod_mode = {3'b011, 3'b010};
    for (int m = 0; m < 3; m++) begin
      cv[m] = 16'($urandom);
      rv[m] = 16'($urandom);
      sfr(1'b1, pct_pkg::ADDR_CPL0 + 8'(2 * m), cv[m][7:0]);
      sfr(1'b1, pct_pkg::ADDR_CPL0 + 8'(2 * m + 1), cv[m][15:8]);
    end
    cmp_val(module_compare_value_q, {cv[2], cv[1], cv[0]});
    sfr(1'b1, pct_pkg::ADDR_PWM, 8'h81);
    for (int m = 0; m < 3; m++) begin
      sfr(1'b1, pct_pkg::ADDR_CPL0 + 8'(2 * m), rv[m][7:0]);
      sfr(1'b1, pct_pkg::ADDR_CPL0 + 8'(2 * m + 1), rv[m][15:8]);
    end
    cmp_val(module_compare_value_q, {cv[2], cv[1], cv[0]});
    rd_chk(pct_pkg::ADDR_CPL0 + 8'h01, rv[0][15:8]);
    sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h40);
    repeat (600) @(posedge sys_clk);
    sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h00);
    cmp_val(module_compare_value_q, {cv[2], cv[1], rv[0]});
    sfr(1'b1, pct_pkg::ADDR_PWM, 8'h01);
    rd_chk(pct_pkg::ADDR_CPL0, rv[0][7:0]);
    // full wrap of the counter, slowest part of the run
    sfr(1'b1, pct_pkg::ADDR_PWM, 8'h00);
    sfr(1'b1, pct_pkg::ADDR_MODE, 8'h09);
    sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h40);
    wait_cnt(16'hFFFF);
    @(posedge sys_clk);
    #1 cmp_val(48'(counter_value_q), 48'h0);
    @(posedge sys_clk);
    #1 cmp_irq(irq_q, 1'b1);
    rd_chk(pct_pkg::ADDR_CTRL, 8'hC0);
    sfr(1'b1, pct_pkg::ADDR_MODE, 8'h08);
    @(posedge sys_clk);
    #1 cmp_irq(irq_q, 1'b0);
    sfr(1'b1, pct_pkg::ADDR_MODE, 8'h09);
    @(posedge sys_clk);
    #1 cmp_irq(irq_q, 1'b1);
    sfr(1'b1, pct_pkg::ADDR_CTRL, 8'h00);
    @(posedge sys_clk);
    #1 cmp_irq(irq_q, 1'b0);
    print_verdict();
  end
endmodule
